/* scr_pkg.sv */
// Shared constants for the self-calibration correction and result block
package scr_pkg;

	// Widths of the calibration registers and channel results
	localparam int CAL_W = 24;
	localparam int RES_W = 16;
	localparam int NUM_CH = 6;

	// Reset values of the calibration registers and results
	localparam logic [23:0] SELF_OFFSET_RST = 24'h000000;
	localparam logic [23:0] SELF_GAIN_RST = 24'hBF851B;
	localparam logic [15:0] RESULT_RST = 16'h0000;

	// Gain words are unsigned with unity at bit 23, so all ones is just under 2x
	localparam int GAIN_FRAC = 23;

	// The stored result is bits 23..8 of the full-scale corrected value
	localparam int RES_LSB = 8;

	// Register selector codes presented with each serial transfer
	localparam logic [3:0] ADDR_SELF_OFFSET = 4'h0;
	localparam logic [3:0] ADDR_SELF_GAIN = 4'h1;
	localparam logic [3:0] ADDR_DATA_BASE = 4'h8;

	// Pipeline depth from raw sample to the saturation stage output
	localparam int LATENCY = 5;

endpackage : scr_pkg

/* scr_shift.sv */
// Serial shift register for MSB-first register transfers
module scr_shift #(
	parameter int W = 24
) (
	input wire logic mclk, // Device clock
	input wire logic rst_n, // Asynchronous reset, active low
	input wire logic load, // Capture parallel read value
	input wire logic [W-1:0] load_data, // Parallel value to shift out
	input wire logic shift, // One bit time
	input wire logic sdi, // Serial data from host
	output logic sdo, // Serial data to host
	output logic [W-1:0] word, // Bits received so far
	output logic [5:0] count // Bits shifted since load
);

	logic [W-1:0] sreg_reg;
	logic [5:0] cnt_reg;

	// Refuse widths the bit counter cannot follow
	if (W < 2 || W > 32) begin : g_bad_w
		$error("scr_shift: W must lie between 2 and 32");
	end

	// Load wins over shift so a new frame starts clean
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sreg_reg <= '0;
		end else if (load) begin
			sreg_reg <= load_data;
		end else if (shift) begin
			sreg_reg <= {sreg_reg[W-2:0], sdi};
		end
	end

	// Counter saturates so overlong frames stay recognisable
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= 6'h00;
		end else if (load) begin
			cnt_reg <= 6'h00;
		end else if (shift && cnt_reg != 6'h3F) begin
			cnt_reg <= cnt_reg + 6'h01;
		end
	end

	assign sdo = sreg_reg[W-1];
	assign word = sreg_reg;
	assign count = cnt_reg;

endmodule : scr_shift

/* scr_sat.sv */
// Final saturation, unipolar doubling and output coding stage
module scr_sat #(
	parameter int IW = 28
) (
	input wire logic mclk, // Device clock
	input wire logic rst_n, // Asynchronous reset, active low
	input wire logic in_valid, // Corrected sample present
	input wire logic [2:0] in_ch, // Channel of the sample
	input wire logic signed [IW-1:0] in_value, // Wide corrected value
	input wire logic unipolar, // Unipolar input range
	input wire logic fmt_offset_binary, // Bipolar coding select
	output logic out_valid, // Result ready, one cycle
	output logic [2:0] out_ch, // Channel of the result
	output logic [15:0] out_res // Clamped 16-bit result
);

	localparam logic signed [IW:0] BI_MAX = (IW+1)'((1 <<< 23) - 1);
	localparam logic signed [IW:0] BI_MIN = -(IW+1)'(1 <<< 23);
	localparam logic signed [IW:0] UNI_MAX = (IW+1)'((1 <<< 24) - 1);

	logic signed [IW:0] wide;
	logic signed [IW:0] clamped;
	logic [15:0] coded;

	// Doubling in unipolar mode comes after every correction
	always_comb begin
		wide = unipolar ? ({in_value, 1'b0}) : {in_value[IW-1], in_value};
		clamped = wide;
		if (unipolar) begin
			if (wide < 0)
				clamped = '0;
			else if (wide > UNI_MAX)
				clamped = UNI_MAX;
		end else begin
			if (wide < BI_MIN)
				clamped = BI_MIN;
			else if (wide > BI_MAX)
				clamped = BI_MAX;
		end
		coded = clamped[scr_pkg::RES_LSB +: 16];
		if (!unipolar && fmt_offset_binary)
			coded[15] = ~coded[15];
	end

	// Registered so the stored result comes straight from a flop
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			out_valid <= 1'b0;
			out_ch <= 3'h0;
			out_res <= scr_pkg::RESULT_RST;
		end else begin
			out_valid <= in_valid;
			out_ch <= in_ch;
			if (in_valid)
				out_res <= coded;
		end
	end

endmodule : scr_sat

/* scr_top.sv */
// Self-calibration correction datapath, calibration registers and channel results
//
// Overview of operation
// - 24-bit read/write self offset register, MSB first, resets to zero.
// - Self offset is always treated as signed two's complement.
// - Self-calibration never overwrites the user offset and gain registers.
// - Readback select 1 returns user value, 0 returns internal register during conversion, zero otherwise.
// - Subtract self offset from each conversion unless its bypass bit is set.
// - Self offset subtraction precedes self gain, system correction and doubling.
// - Host writes to both self-calibration registers ignored during self-calibration.
// - 24-bit unsigned read/write self gain register, MSB first, printed reset value.
// - Unless bypassed, multiply offset-corrected result by self gain before system stages.
// - Self gain spans up to twice unity, corrected within two LSB.
// - One result register per channel zero to five, updated with final result.
// - Channel results are 16-bit read-only; host writes change nothing.
// - Channel results shift out to host MSB first.
// - Unipolar results are offset binary, zero lowest, 0x8000 midscale.
// - Bipolar format bit picks offset binary at 1, two's complement at 0.
// - Out-of-range results saturate at minimum or maximum code, never wrap.
// - Unless bypassed, system offset subtracts after self correction, before system gain.
module scr_top #(
	parameter int NUM_CH = scr_pkg::NUM_CH,
	parameter int IW = 28
) (
	input wire logic mclk, // Device clock, 100 MHz
	input wire logic rst_n, // Asynchronous reset, active low
	input wire logic xfer_start, // Register transfer begins
	input wire logic xfer_end, // Register transfer ends
	input wire logic xfer_write, // Transfer is a write
	input wire logic [3:0] reg_addr, // Register selector
	input wire logic bit_strobe, // One serial bit time
	input wire logic sdi, // Serial data in
	output logic sdo, // Serial data out
	input wire logic cal_readback_select, // 1 user value, 0 internal while converting
	input wire logic bypass_self_offset, // Skip self offset stage
	input wire logic bypass_self_gain, // Skip self gain stage
	input wire logic bypass_system_offset, // Skip system offset stage
	input wire logic bypass_system_gain, // Skip system gain stage
	input wire logic unipolar, // Unipolar input range
	input wire logic fmt_offset_binary, // Bipolar coding select
	input wire logic self_cal_busy, // Self-calibration running
	input wire logic conversion_active, // Conversion in progress
	input wire logic [23:0] int_self_offset, // Internal self-cal offset
	input wire logic [23:0] int_self_gain, // Internal self-cal gain
	input wire logic [23:0] system_offset, // System offset, signed
	input wire logic [23:0] system_gain, // System gain, unsigned
	input wire logic raw_valid, // Raw conversion present
	input wire logic [2:0] raw_channel, // Channel of raw sample
	input wire logic [23:0] raw_data, // Raw sample, signed
	output logic result_valid, // Result stored, one cycle
	output logic [2:0] result_channel, // Channel just stored
	output logic [15:0] result_value, // Value just stored
	output logic [23:0] self_offset_value, // User self offset
	output logic [23:0] self_gain_value, // User self gain
	output logic write_refused // Write dropped while busy
);

	localparam int PW = IW + 25;
	localparam int CW = scr_pkg::CAL_W;

	// Refuse settings the datapath or channel field cannot carry
	if (NUM_CH < 1 || NUM_CH > 8) begin : g_bad_num_ch
		$error("scr_top: NUM_CH must lie between 1 and 8");
	end
	if (IW < 26 || IW > 40) begin : g_bad_iw
		$error("scr_top: IW must lie between 26 and 40");
	end

	// Clamp a wide intermediate back to the internal width
	function automatic logic signed [IW-1:0] sat_iw(input logic signed [PW-1:0] p);
		logic [PW-IW:0] top;
		top = p[PW-1:IW-1];
		if (&top || ~|top)
			sat_iw = p[IW-1:0];
		else if (p[PW-1])
			sat_iw = {1'b1, {(IW-1){1'b0}}};
		else
			sat_iw = {1'b0, {(IW-1){1'b1}}};
	endfunction : sat_iw

	// Sign-extend a 24-bit two's complement word to the wide width
	function automatic logic signed [PW-1:0] ext24(input logic [23:0] v);
		ext24 = {{(PW-24){v[23]}}, v};
	endfunction : ext24

	// Sign-extend an internal-width value to the wide width
	function automatic logic signed [PW-1:0] extw(input logic signed [IW-1:0] v);
		extw = {{(PW-IW){v[IW-1]}}, v};
	endfunction : extw

	// Gain scaling: unsigned gain, unity at the fraction point, up to 2x
	function automatic logic signed [IW-1:0] scale(input logic signed [IW-1:0] v,
		input logic [23:0] g);
		logic signed [PW-1:0] prod;
		prod = extw(v) * $signed({{(PW-24){1'b0}}, g});
		scale = sat_iw(prod >>> scr_pkg::GAIN_FRAC);
	endfunction : scale

	logic [23:0] self_offset_reg;
	logic [23:0] self_gain_reg;
	logic [15:0] result_mem [NUM_CH];
	logic [CW-1:0] rd_word;
	logic [CW-1:0] rx_word;
	logic [5:0] rx_count;
	logic cal_write;
	logic write_refused_reg;

	// Stage registers of the correction pipeline
	logic s1_valid_reg, s2_valid_reg, s3_valid_reg, s4_valid_reg;
	logic [2:0] s1_ch_reg, s2_ch_reg, s3_ch_reg, s4_ch_reg;
	logic signed [IW-1:0] s1_reg, s2_reg, s3_reg, s4_reg;
	logic signed [IW-1:0] s1_next, s2_next, s3_next, s4_next;

	logic sat_valid;
	logic [2:0] sat_ch;
	logic [15:0] sat_res;

	// Read value chosen when a transfer starts
	always_comb begin
		rd_word = '0;
		if (reg_addr == scr_pkg::ADDR_SELF_OFFSET) begin
			if (cal_readback_select)
				rd_word = self_offset_reg;
			else if (conversion_active)
				rd_word = int_self_offset;
		end else if (reg_addr == scr_pkg::ADDR_SELF_GAIN) begin
			if (cal_readback_select)
				rd_word = self_gain_reg;
			else if (conversion_active)
				rd_word = int_self_gain;
		end else if (reg_addr >= scr_pkg::ADDR_DATA_BASE &&
			{1'b0, reg_addr} < {1'b0, scr_pkg::ADDR_DATA_BASE} + 5'(NUM_CH)) begin
			// Left-aligned so the 16-bit result leaves MSB first
			rd_word = {result_mem[3'(reg_addr - scr_pkg::ADDR_DATA_BASE)],
				8'h00};
		end
	end

	// Shared serial shifter for all registers
	scr_shift #(
		.W(CW)
	) u_shift (
		.mclk(mclk),
		.rst_n(rst_n),
		.load(xfer_start),
		.load_data(rd_word),
		.shift(bit_strobe),
		.sdi(sdi),
		.sdo(sdo),
		.word(rx_word),
		.count(rx_count)
	);

	// Only complete 24-bit frames to a calibration register commit
	assign cal_write = xfer_end && xfer_write && rx_count == 6'(CW) &&
		(reg_addr == scr_pkg::ADDR_SELF_OFFSET || reg_addr == scr_pkg::ADDR_SELF_GAIN);

	// User self offset; the self-calibration engine has its own copy
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			self_offset_reg <= scr_pkg::SELF_OFFSET_RST;
		end else if (cal_write && !self_cal_busy &&
			reg_addr == scr_pkg::ADDR_SELF_OFFSET) begin
			self_offset_reg <= rx_word;
		end
	end

	// User self gain, same protection while calibration runs
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			self_gain_reg <= scr_pkg::SELF_GAIN_RST;
		end else if (cal_write && !self_cal_busy &&
			reg_addr == scr_pkg::ADDR_SELF_GAIN) begin
			self_gain_reg <= rx_word;
		end
	end

	// Flag a dropped write so software can retry after calibration
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			write_refused_reg <= 1'b0;
		else
			write_refused_reg <= cal_write && self_cal_busy;
	end

	// Stage 1: self offset, always signed, first of all corrections
	always_comb begin
		if (bypass_self_offset)
			s1_next = sat_iw(ext24(raw_data));
		else
			s1_next = sat_iw(ext24(raw_data) - ext24(self_offset_reg));
	end

	// Stage 2: self gain on the offset-corrected value
	always_comb begin
		if (bypass_self_gain)
			s2_next = s1_reg;
		else
			s2_next = scale(s1_reg, self_gain_reg);
	end

	// Stage 3: system offset after both self-calibration stages
	always_comb begin
		if (bypass_system_offset)
			s3_next = s2_reg;
		else
			s3_next = sat_iw(extw(s2_reg) - ext24(system_offset));
	end

	// Stage 4: system gain last; wide values kept to avoid early clipping
	always_comb begin
		if (bypass_system_gain)
			s4_next = s3_reg;
		else
			s4_next = scale(s3_reg, system_gain);
	end

	// Pipeline valid and channel tags follow the data
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s1_valid_reg <= 1'b0;
			s2_valid_reg <= 1'b0;
			s3_valid_reg <= 1'b0;
			s4_valid_reg <= 1'b0;
			s1_ch_reg <= 3'h0;
			s2_ch_reg <= 3'h0;
			s3_ch_reg <= 3'h0;
			s4_ch_reg <= 3'h0;
		end else begin
			s1_valid_reg <= raw_valid;
			s2_valid_reg <= s1_valid_reg;
			s3_valid_reg <= s2_valid_reg;
			s4_valid_reg <= s3_valid_reg;
			s1_ch_reg <= raw_channel;
			s2_ch_reg <= s1_ch_reg;
			s3_ch_reg <= s2_ch_reg;
			s4_ch_reg <= s3_ch_reg;
		end
	end

	// Pipeline data, held when no sample is moving
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			s4_reg <= '0;
		end else begin
			if (raw_valid)
				s1_reg <= s1_next;
			if (s1_valid_reg)
				s2_reg <= s2_next;
			if (s2_valid_reg)
				s3_reg <= s3_next;
			if (s3_valid_reg)
				s4_reg <= s4_next;
		end
	end

	// Stage 5: doubling, saturation and coding down to 16 bits
	scr_sat #(
		.IW(IW)
	) u_sat (
		.mclk(mclk),
		.rst_n(rst_n),
		.in_valid(s4_valid_reg),
		.in_ch(s4_ch_reg),
		.in_value(s4_reg),
		.unipolar(unipolar),
		.fmt_offset_binary(fmt_offset_binary),
		.out_valid(sat_valid),
		.out_ch(sat_ch),
		.out_res(sat_res)
	);

	// Channel results change only from the datapath, never from a host write
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < NUM_CH; i++)
				result_mem[i] <= scr_pkg::RESULT_RST;
		end else if (sat_valid && 32'(sat_ch) < NUM_CH) begin
			result_mem[sat_ch] <= sat_res;
		end
	end

	// Report each stored result; out-of-range channels are dropped silently
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			result_valid <= 1'b0;
			result_channel <= 3'h0;
			result_value <= scr_pkg::RESULT_RST;
		end else begin
			result_valid <= sat_valid && 32'(sat_ch) < NUM_CH;
			if (sat_valid && 32'(sat_ch) < NUM_CH) begin
				result_channel <= sat_ch;
				result_value <= sat_res;
			end
		end
	end

	assign self_offset_value = self_offset_reg;
	assign self_gain_value = self_gain_reg;
	assign write_refused = write_refused_reg;

endmodule : scr_top

/* scr_host_model.sv */
// Host-side serial register master driving the correction block
module scr_host_model (
	input wire logic mclk, // Device clock
	input wire logic sdo, // Serial data from device
	output logic xfer_start, // Transfer begins
	output logic xfer_end, // Transfer ends
	output logic xfer_write, // Write transfer
	output logic [3:0] reg_addr, // Register selector
	output logic bit_strobe, // One bit time
	output logic sdi // Serial data to device
);
	timeunit 1ns;
	timeprecision 1ps;
	// Idle bus at time zero
	initial begin
		{xfer_start, xfer_end, xfer_write, bit_strobe, sdi} = 5'h00;
		reg_addr = 4'h0;
	end
	// One framed transfer; strobe stays high across back-to-back bits
	task automatic xfer(input logic wr, input logic [3:0] a, input logic [23:0] wd,
		input int n, output logic [23:0] rd);
		rd = 24'h000000;
		@(posedge mclk);
		#1;
		xfer_start = 1'b1;
		xfer_write = wr;
		reg_addr = a;
		@(posedge mclk);
		#1;
		xfer_start = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			rd = {rd[22:0], sdo};
			sdi = wd[i];
			bit_strobe = 1'b1;
			@(posedge mclk);
			#1;
		end
		bit_strobe = 1'b0;
		sdi = ~sdi; // Idle line never repeats the last bit
		xfer_end = 1'b1;
		@(posedge mclk);
		#1;
		xfer_end = 1'b0;
	endtask : xfer
endmodule : scr_host_model

/* scr_top_sva.sv */
// Assertion checker for the self-calibration correction block
module scr_top_sva #(
	parameter int NUM_CH = 6
) (
	input wire logic mclk, // Device clock
	input wire logic rst_n, // Async reset, active low
	input wire logic xfer_start, // Transfer begins
	input wire logic xfer_end, // Transfer ends
	input wire logic xfer_write, // Write transfer
	input wire logic [3:0] reg_addr, // Register selector
	input wire logic bit_strobe, // Bit time
	input wire logic sdi, // Serial in
	input wire logic sdo, // Serial out
	input wire logic cal_readback_select, // Readback select
	input wire logic self_cal_busy, // Self-cal running
	input wire logic conversion_active, // Converting
	input wire logic raw_valid, // Raw sample
	input wire logic [2:0] raw_channel, // Raw channel
	input wire logic result_valid, // Result stored
	input wire logic [2:0] result_channel, // Stored channel
	input wire logic [23:0] self_offset_value, // User offset
	input wire logic [23:0] self_gain_value, // User gain
	input wire logic write_refused // Busy write dropped
);
	logic [5:0] cnt_reg; // Strobes since start, saturating
	logic [23:0] sh_reg; // Last 24 bits shifted in
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// Frame length and written word as the host sent them
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= 6'h00;
			sh_reg <= 24'h000000;
		end else if (xfer_start) begin
			cnt_reg <= 6'h00;
		end else if (bit_strobe) begin
			cnt_reg <= (cnt_reg == 6'h3F) ? cnt_reg : cnt_reg + 6'h01;
			sh_reg <= {sh_reg[22:0], sdi};
		end
	end
	// Complete 24-bit write frame to one address
	sequence s_wr(a);
		xfer_end && xfer_write && reg_addr == a && cnt_reg == 6'h18;
	endsequence
	AST_OFS_WR: assert property (s_wr(4'h0) ##0 !self_cal_busy |=> self_offset_value == $past(sh_reg))
		else $error("offset write not stored");
	AST_GAIN_WR: assert property (s_wr(4'h1) ##0 !self_cal_busy |=> self_gain_value == $past(sh_reg))
		else $error("gain write not stored");
	AST_BUSY_REFUSE: assert property ((s_wr(4'h0) or s_wr(4'h1)) ##0 self_cal_busy |=> write_refused && $stable(self_offset_value) && $stable(self_gain_value))
		else $error("write accepted while busy");
	AST_USER_HOLD: assert property (!xfer_end |=> $stable(self_offset_value) && $stable(self_gain_value))
		else $error("user cal register changed without write");
	AST_RD_USER: assert property (xfer_start && reg_addr == 4'h0 && cal_readback_select |=> sdo == $past(self_offset_value[23]))
		else $error("user readback MSB wrong");
	AST_RD_INT0: assert property (xfer_start && reg_addr == 4'h1 && !cal_readback_select && !conversion_active |=> !sdo)
		else $error("internal readback not zero outside conversion");
	AST_RES_LAT: assert property (raw_valid && raw_channel < NUM_CH |-> ##6 result_valid && result_channel == $past(raw_channel, 6))
		else $error("result late or on wrong channel");
	AST_NO_STRAY: assert property (result_valid |-> $past(raw_valid, 6) && $past(raw_channel, 6) < NUM_CH)
		else $error("result without stored sample");
	AST_RST_VAL: assert property ($rose(rst_n) |-> self_gain_value == 24'hBF851B && self_offset_value == 24'h000000)
		else $error("cal register reset value wrong");
endmodule : scr_top_sva

bind scr_top scr_top_sva #(.NUM_CH(NUM_CH)) scr_top_sva_inst (.mclk, .rst_n, .xfer_start,
	.xfer_end, .xfer_write, .reg_addr, .bit_strobe, .sdi, .sdo, .cal_readback_select,
	.self_cal_busy, .conversion_active, .raw_valid, .raw_channel, .result_valid,
	.result_channel, .self_offset_value, .self_gain_value, .write_refused);

/* scr_top_tb_top.sv */
// Self-checking bench for the self-calibration correction block
module scr_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam longint LO = -(64'sd1 <<< 27);
	localparam longint HI = (64'sd1 <<< 27) - 1;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic xfer_start, xfer_end, xfer_write, bit_strobe, sdi, sdo, res_valid, refused;
	logic [3:0] reg_addr, ch;
	logic sel = 1'b1, bso = 1'b0, bsg = 1'b0, bsyo = 1'b0, bsyg = 1'b0, uni = 1'b0, fmt = 1'b0;
	logic busy = 1'b0, conv = 1'b0, raw_valid = 1'b0;
	logic [2:0] raw_ch = 3'h0, res_ch;
	logic [23:0] int_so = 24'h0, int_g = 24'h0, sof = 24'h0, sg = 24'h800000, raw = 24'h0;
	logic [23:0] so_v, g_v, rd, nso, ng;
	logic [23:0] so_m = 24'h000000, g_m = 24'hBF851B; // Expected user registers
	logic [15:0] res_v;
	logic [15:0] last [6] = '{default: 16'h0000};
	logic [23:0] q [$];
	int n_mismatch = 0, samples_checked = 0, n;
	always #5 mclk = ~mclk;
	scr_top scr_top_inst (.mclk, .rst_n, .xfer_start, .xfer_end, .xfer_write, .reg_addr,
		.bit_strobe, .sdi, .sdo, .cal_readback_select(sel), .bypass_self_offset(bso),
		.bypass_self_gain(bsg), .bypass_system_offset(bsyo), .bypass_system_gain(bsyg),
		.unipolar(uni), .fmt_offset_binary(fmt), .self_cal_busy(busy),
		.conversion_active(conv), .int_self_offset(int_so), .int_self_gain(int_g),
		.system_offset(sof), .system_gain(sg), .raw_valid, .raw_channel(raw_ch),
		.raw_data(raw), .result_valid(res_valid), .result_channel(res_ch),
		.result_value(res_v), .self_offset_value(so_v), .self_gain_value(g_v),
		.write_refused(refused));
	scr_host_model scr_host_model_inst (.mclk, .sdo, .xfer_start, .xfer_end, .xfer_write,
		.reg_addr, .bit_strobe, .sdi);
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic test_done();
		$display("checked=%0d mismatches=%0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : test_done
	task automatic rw(input logic w, input logic [3:0] a, input logic [23:0] d, input int k);
		scr_host_model_inst.xfer(w, a, d, k, rd);
	endtask : rw
	function automatic longint clip(input longint v, input longint lo, input longint hi);
		return (v < lo) ? lo : (v > hi) ? hi : v;
	endfunction : clip
	// Reference of the whole correction chain, clamped to the internal width after every stage
	function automatic logic [15:0] exp_res(input logic [23:0] r);
		longint x;
		x = longint'($signed(r));
		if (!bso) x = clip(x - longint'($signed(so_m)), LO, HI);
		if (!bsg) x = clip((x * longint'(g_m)) >>> 23, LO, HI);
		if (!bsyo) x = clip(x - longint'($signed(sof)), LO, HI);
		if (!bsyg) x = clip((x * longint'(sg)) >>> 23, LO, HI);
		if (uni) begin
			x = clip(2 * x, 0, 64'sh0FFFFFF);
			return x[23:8];
		end
		x = clip(x, -(64'sd1 <<< 23), (64'sd1 <<< 23) - 1);
		return {x[23] ^ fmt, x[22:8]};
	endfunction : exp_res
	initial begin
		void'($urandom(32'hDC34));
		repeat (6) @(posedge mclk);
		#1;
		rst_n = 1'b1;
		rw(0, 4'h1, 24'h0, 24);
		chk(rd, 24'hBF851B);
		rw(0, 4'h0, 24'h0, 24);
		chk(rd, 24'h000000);
		for (int it = 0; it < 40; it++) begin
			// Random coding, bypasses and system terms; busy or short frames now and then
			{bso, bsg, bsyo, bsyg, uni, fmt} = 6'($urandom);
			{sof, sg, int_so, int_g} = {24'($urandom), 24'($urandom), 24'($urandom), 24'($urandom)};
			busy = ($urandom % 4 == 0);
			n = ($urandom % 5 == 0) ? 23 : 24;
			nso = 24'($urandom);
			ng = (it < 4) ? 24'hFFFFFF : 24'($urandom);
			rw(1, 4'h0, nso, n);
			chk({23'h0, refused}, {23'h0, busy && n == 24});
			rw(1, 4'h1, ng, n);
			chk({23'h0, refused}, {23'h0, busy && n == 24});
			if (!busy && n == 24) begin
				so_m = nso;
				g_m = ng;
			end
			busy = 1'b0;
			chk(so_v, so_m);
			chk(g_v, g_m);
			sel = 1'b1;
			rw(0, 4'h0, 24'h0, 24);
			chk(rd, so_m);
			rw(0, 4'h1, 24'h0, 24);
			chk(rd, g_m);
			sel = 1'b0;
			conv = 1'($urandom);
			rw(0, 4'h1, 24'h0, 24);
			chk(rd, conv ? int_g : 24'h0);
			rw(0, 4'h0, 24'h0, 24);
			chk(rd, conv ? int_so : 24'h0);
			sel = 1'b1;
			// Back-to-back samples, one channel out of range now and then
			for (int k = 0; k < 6; k++) begin
				raw_ch = (k == 5 && it % 3 == 0) ? 3'h6 : 3'($urandom % 6);
				raw = (it < 4) ? (k[0] ? 24'h7FFFFF : 24'h800000) : 24'($urandom);
				raw_valid = 1'b1;
				if (raw_ch < 3'h6) begin
					last[raw_ch] = exp_res(raw);
					q.push_back({5'h00, raw_ch, last[raw_ch]});
				end
				@(posedge mclk);
				#1;
			end
			raw_valid = 1'b0;
			// First result already stands just after the edge that takes the last sample
			for (int c = 0; c < 12 && q.size() > 0; c++) begin
				if (res_valid === 1'b1)
					chk({5'h00, res_ch, res_v}, q.pop_front());
				@(posedge mclk);
				#1;
			end
			if (q.size() != 0) begin
				n_mismatch++;
				test_done();
			end
			// Data register ignores writes and reads back MSB first
			ch = 4'($urandom % 6);
			rw(1, 4'h8 + ch, 24'($urandom), 24);
			rw(0, 4'h8 + ch, 24'h0, 16);
			chk(rd, {8'h00, last[ch]});
		end
		test_done();
	end
endmodule : scr_top_tb_top
